// File: common/engine_mac_adapter_defines.vh
`ifndef ENGINE_MAC_ADAPTER_DEFINES_VH
`define ENGINE_MAC_ADAPTER_DEFINES_VH

// ============================================================
// Packet FIFO geometry
`define PKT_FIFO_WIDTH 258
`define PKT_FIFO_DEPTH 512
`define PKT_FIFO_AW    9
`define PKT_FIFO_CW    10
`define DATA_W         256
`define BE_W           32

// ============================================================
// FIFO word layout: {byte-enable select, last, data}
`define WORD_LAST_BIT  256
`define WORD_BESEL_BIT 257
`define BE_SEL_BIT     27

// ============================================================
// Byte enable patterns: full body word, long and short last word
`define KEEP_ALL       32'hffffffff
`define KEEP_LONG      32'h0fffffff
`define KEEP_SHORT     32'h003fffff

// ============================================================
// Packet counters and receive admission
`define PKT_CNT_W      10
`define PKT_CNT_ZERO   10'h000
`define PKT_CNT_ONE    10'h001
`define RX_ADMIT_LIMIT 10'h0e0

// ============================================================
// State codes
`define ST_W           2
`define ST_IDLE        2'h0
`define ST_UPDATE      2'h1
`define ST_TRANSFER    2'h2
`define ST_DROP        2'h3

`endif

// File: verilog/async_packet_fifo.v
`timescale 1ns/100ps
`include "engine_mac_adapter_defines.vh"

module async_packet_fifo #(
    parameter WIDTH = `PKT_FIFO_WIDTH,
    parameter DEPTH = `PKT_FIFO_DEPTH,
    parameter AW    = `PKT_FIFO_AW
) (
    input  wire             i_wr_clk,
    input  wire             i_wr_rst_n,
    input  wire             i_wr_valid,
    input  wire [WIDTH-1:0] i_wr_data,
    output wire             o_wr_ready,
    output wire [AW:0]      o_wr_count,
    input  wire             i_rd_clk,
    input  wire             i_rd_rst_n,
    output wire             o_rd_valid,
    input  wire             i_rd_ready,
    output wire [WIDTH-1:0] o_rd_data
);

    // ============================================================
    // Pointer helpers
    function [AW:0] bin2gray;
        input [AW:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    function [AW:0] gray2bin;
        input [AW:0] g;
        integer k;
        begin
            gray2bin[AW] = g[AW];
            for (k = AW - 1; k >= 0; k = k - 1) begin
                gray2bin[k] = gray2bin[k + 1] ^ g[k];
            end
        end
    endfunction

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // ============================================================
    // Write side
    reg  [AW:0] wbin_q;
    reg  [AW:0] wgray_q;
    reg  [AW:0] rgray_read_q;
    reg  [AW:0] rgray_s1_q;
    reg  [AW:0] rgray_s2_q;
    reg         wr_ready_q;
    reg  [AW:0] wr_count_q;
    wire        push      = i_wr_valid & wr_ready_q;
    wire [AW:0] wbin_d    = wbin_q + {{AW{1'b0}}, push};
    wire [AW:0] wgray_d   = bin2gray(wbin_d);
    wire [AW:0] full_gray = {~rgray_s2_q[AW:AW-1], rgray_s2_q[AW-2:0]};

    always @(posedge i_wr_clk) begin
        if (push) begin
            mem[wbin_q[AW-1:0]] <= i_wr_data;
        end
    end

    always @(posedge i_wr_clk or negedge i_wr_rst_n) begin
        if (!i_wr_rst_n) begin
            wbin_q     <= {(AW+1){1'b0}};
            wgray_q    <= {(AW+1){1'b0}};
            rgray_s1_q <= {(AW+1){1'b0}};
            rgray_s2_q <= {(AW+1){1'b0}};
            wr_ready_q <= 1'b0;
            wr_count_q <= {(AW+1){1'b0}};
        end else begin
            wbin_q     <= wbin_d;
            wgray_q    <= wgray_d;
            rgray_s1_q <= rgray_read_q;
            rgray_s2_q <= rgray_s1_q;
            wr_ready_q <= (wgray_d != full_gray);
            // Lags real occupancy, so it only ever overstates the fill
            wr_count_q <= wbin_d - gray2bin(rgray_s2_q);
        end
    end

    // ============================================================
    // Read side, first word shown ahead
    reg  [AW:0]      rbin_q;
    reg  [AW:0]      wgray_s1_q;
    reg  [AW:0]      wgray_s2_q;
    reg              rd_valid_q;
    reg  [WIDTH-1:0] rd_data_q;
    wire             pop     = i_rd_ready & rd_valid_q;
    wire [AW:0]      rbin_d  = rbin_q + {{AW{1'b0}}, pop};
    wire [AW:0]      rgray_d = bin2gray(rbin_d);

    always @(posedge i_rd_clk) begin
        rd_data_q <= mem[rbin_d[AW-1:0]];
    end

    always @(posedge i_rd_clk or negedge i_rd_rst_n) begin
        if (!i_rd_rst_n) begin
            rbin_q       <= {(AW+1){1'b0}};
            rgray_read_q <= {(AW+1){1'b0}};
            wgray_s1_q   <= {(AW+1){1'b0}};
            wgray_s2_q   <= {(AW+1){1'b0}};
            rd_valid_q   <= 1'b0;
        end else begin
            rbin_q       <= rbin_d;
            rgray_read_q <= rgray_d;
            wgray_s1_q   <= wgray_q;
            wgray_s2_q   <= wgray_s1_q;
            rd_valid_q   <= (rgray_d != wgray_s2_q);
        end
    end

    assign o_wr_ready = wr_ready_q;
    assign o_wr_count = wr_count_q;
    assign o_rd_valid = rd_valid_q;
    assign o_rd_data  = rd_data_q;

endmodule // async_packet_fifo

// File: verilog/engine_mac_adapter.v
// Function
// - Three asynchronous clock domains.
// - One 512 by 258 dual-clock FIFO each way.
// - Engine owns transmit FIFO writes, receive FIFO reads.
// - Packet ends counted, count crosses to transmit clock.
// - Remaining is written minus started packets.
// - Only byte-enable bit 27 is stored, for every word.
// - Start when remaining nonzero and FIFO not empty.
// - Update lasts one cycle, decrements remaining.
// - Read when busy and MAC ready; loads data, sets valid.
// - Ready low: stop reading, hold data.
// - Valid to frame end; idle and valid low after last.
// - Fill below 224 admits a new receive packet.
// - Receive writes registered from stream valid, data.
// - Valid with last returns receive machine to idle.
// - Fill 224 or more drops packet to its last beat.
`timescale 1ns/100ps
`include "engine_mac_adapter_defines.vh"

module engine_mac_adapter (
    input  wire               i_ref_clk,
    input  wire               i_arst_n,
    input  wire               i_mac_tx_clk,
    input  wire               i_mac_rx_clk,
    input  wire               i_eng_tx_wr_en,
    input  wire [`DATA_W-1:0] i_eng_tx_data,
    input  wire               i_eng_tx_last,
    input  wire [`BE_W-1:0]   i_eng_tx_byte_en,
    output wire               o_eng_tx_ready,
    input  wire               i_eng_rx_rd_en,
    output wire               o_eng_rx_valid,
    output wire [`DATA_W-1:0] o_eng_rx_data,
    output wire               o_eng_rx_last,
    output wire               o_eng_rx_be_sel,
    output reg  [`DATA_W-1:0] o_mac_tx_tdata,
    output reg                o_mac_tx_tvalid,
    output reg                o_mac_tx_tlast,
    output reg  [`BE_W-1:0]   o_mac_tx_tkeep,
    input  wire               i_mac_tx_tready,
    input  wire [`DATA_W-1:0] i_mac_rx_tdata,
    input  wire               i_mac_rx_tvalid,
    input  wire               i_mac_rx_tlast,
    input  wire [`BE_W-1:0]   i_mac_rx_tkeep
);

    // ============================================================
    // Gray helpers for the packet counter crossing
    function [`PKT_CNT_W-1:0] cnt2gray;
        input [`PKT_CNT_W-1:0] b;
        begin
            cnt2gray = b ^ (b >> 1);
        end
    endfunction

    function [`PKT_CNT_W-1:0] gray2cnt;
        input [`PKT_CNT_W-1:0] g;
        integer k;
        begin
            gray2cnt[`PKT_CNT_W-1] = g[`PKT_CNT_W-1];
            for (k = `PKT_CNT_W - 2; k >= 0; k = k - 1) begin
                gray2cnt[k] = gray2cnt[k + 1] ^ g[k];
            end
        end
    endfunction

    // ============================================================
    // Reset release per clock domain
    reg eng_rst_s1_q;
    reg eng_rst_n_q;
    reg tx_rst_s1_q;
    reg tx_rst_n_q;
    reg rx_rst_s1_q;
    reg rx_rst_n_q;

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {eng_rst_n_q, eng_rst_s1_q} <= 2'h0;
        end else begin
            {eng_rst_n_q, eng_rst_s1_q} <= {eng_rst_s1_q, 1'b1};
        end
    end

    always @(posedge i_mac_tx_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {tx_rst_n_q, tx_rst_s1_q} <= 2'h0;
        end else begin
            {tx_rst_n_q, tx_rst_s1_q} <= {tx_rst_s1_q, 1'b1};
        end
    end

    always @(posedge i_mac_rx_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {rx_rst_n_q, rx_rst_s1_q} <= 2'h0;
        end else begin
            {rx_rst_n_q, rx_rst_s1_q} <= {rx_rst_s1_q, 1'b1};
        end
    end

    // ============================================================
    // Transmit FIFO
    wire                       tx_wr_ready;
    wire                       tx_rd_valid;
    wire                       transmit_fifo_read_enable;
    wire [`PKT_FIFO_WIDTH-1:0] tx_rd_word;
    wire [`PKT_FIFO_WIDTH-1:0] tx_wr_word;

    // Last-word enables take two values, so one bit is enough
    assign tx_wr_word = {i_eng_tx_byte_en[`BE_SEL_BIT],
                         i_eng_tx_last, i_eng_tx_data};

    async_packet_fifo #(
        .WIDTH (`PKT_FIFO_WIDTH),
        .DEPTH (`PKT_FIFO_DEPTH),
        .AW    (`PKT_FIFO_AW)
    ) transmit_packet_fifo (
        .i_wr_clk   (i_ref_clk),
        .i_wr_rst_n (eng_rst_n_q),
        .i_wr_valid (i_eng_tx_wr_en),
        .i_wr_data  (tx_wr_word),
        .o_wr_ready (tx_wr_ready),
        .o_wr_count (),
        .i_rd_clk   (i_mac_tx_clk),
        .i_rd_rst_n (tx_rst_n_q),
        .o_rd_valid (tx_rd_valid),
        .i_rd_ready (transmit_fifo_read_enable),
        .o_rd_data  (tx_rd_word)
    );

    assign o_eng_tx_ready = tx_wr_ready;

    // ============================================================
    // Written-packet counter, engine domain
    reg [`PKT_CNT_W-1:0] written_packet_count_q;
    reg [`PKT_CNT_W-1:0] written_gray_q;

    always @(posedge i_ref_clk or negedge eng_rst_n_q) begin
        if (!eng_rst_n_q) begin
            written_packet_count_q <= `PKT_CNT_ZERO;
            written_gray_q         <= `PKT_CNT_ZERO;
        end else begin
            if (i_eng_tx_wr_en && tx_wr_ready && i_eng_tx_last) begin
                written_packet_count_q <= written_packet_count_q
                                          + `PKT_CNT_ONE;
            end
            // Gray copy: one bit moves per packet
            written_gray_q <= cnt2gray(written_packet_count_q);
        end
    end

    // ============================================================
    // Packet count crossing, transmit domain
    reg [`PKT_CNT_W-1:0] written_gray_s1_q;
    reg [`PKT_CNT_W-1:0] written_gray_s2_q;
    reg [`PKT_CNT_W-1:0] read_packet_count_q;
    reg [`PKT_CNT_W-1:0] remaining_packet_count_q;
    reg [`ST_W-1:0]      transmit_state_q;
    reg [`ST_W-1:0]      transmit_state_d;

    always @(posedge i_mac_tx_clk or negedge tx_rst_n_q) begin
        if (!tx_rst_n_q) begin
            written_gray_s1_q        <= `PKT_CNT_ZERO;
            written_gray_s2_q        <= `PKT_CNT_ZERO;
            read_packet_count_q      <= `PKT_CNT_ZERO;
            remaining_packet_count_q <= `PKT_CNT_ZERO;
        end else begin
            written_gray_s1_q <= written_gray_q;
            written_gray_s2_q <= written_gray_s1_q;
            if (transmit_state_q == `ST_UPDATE) begin
                read_packet_count_q <= read_packet_count_q
                                       + `PKT_CNT_ONE;
            end
            remaining_packet_count_q <= gray2cnt(written_gray_s2_q)
                                        - read_packet_count_q;
        end
    end

    // ============================================================
    // Transmit state machine
    localparam [`ST_W-1:0] TX_IDLE     = `ST_IDLE;
    localparam [`ST_W-1:0] TX_UPDATE   = `ST_UPDATE;
    localparam [`ST_W-1:0] TX_TRANSFER = `ST_TRANSFER;

    // No fetch once the last beat sits in the output register
    wire tx_last_pending = o_mac_tx_tvalid & o_mac_tx_tlast;
    wire tx_beat_done    = tx_last_pending & i_mac_tx_tready;
    assign transmit_fifo_read_enable = (transmit_state_q != TX_IDLE)
                                       & i_mac_tx_tready
                                       & tx_rd_valid
                                       & ~tx_last_pending;

    always @* begin
        transmit_state_d = transmit_state_q;
        case (transmit_state_q)
            TX_IDLE: begin
                if ((remaining_packet_count_q != `PKT_CNT_ZERO)
                    && tx_rd_valid) begin
                    transmit_state_d = TX_UPDATE;
                end
            end
            TX_UPDATE: begin
                transmit_state_d = TX_TRANSFER;
            end
            TX_TRANSFER: begin
                if (tx_beat_done) begin
                    transmit_state_d = TX_IDLE;
                end
            end
            default: begin
                transmit_state_d = TX_IDLE;
            end
        endcase
    end

    always @(posedge i_mac_tx_clk or negedge tx_rst_n_q) begin
        if (!tx_rst_n_q) begin
            transmit_state_q <= TX_IDLE;
            o_mac_tx_tdata   <= {`DATA_W{1'b0}};
            o_mac_tx_tvalid  <= 1'b0;
            o_mac_tx_tlast   <= 1'b0;
            o_mac_tx_tkeep   <= `KEEP_ALL;
        end else begin
            transmit_state_q <= transmit_state_d;
            if (transmit_fifo_read_enable) begin
                o_mac_tx_tdata  <= tx_rd_word[`DATA_W-1:0];
                o_mac_tx_tvalid <= 1'b1;
                o_mac_tx_tlast  <= tx_rd_word[`WORD_LAST_BIT];
                if (!tx_rd_word[`WORD_LAST_BIT]) begin
                    o_mac_tx_tkeep <= `KEEP_ALL;
                end else if (tx_rd_word[`WORD_BESEL_BIT]) begin
                    o_mac_tx_tkeep <= `KEEP_LONG;
                end else begin
                    o_mac_tx_tkeep <= `KEEP_SHORT;
                end
            end else if (tx_beat_done) begin
                o_mac_tx_tvalid <= 1'b0;
                o_mac_tx_tlast  <= 1'b0;
            end
        end
    end

    // ============================================================
    // Receive FIFO
    wire [`PKT_FIFO_CW-1:0]    receive_fifo_fill_count;
    wire                       rx_rd_valid;
    wire [`PKT_FIFO_WIDTH-1:0] rx_rd_word;
    reg                        receive_fifo_write_enable_q;
    reg  [`PKT_FIFO_WIDTH-1:0] receive_fifo_write_data_q;

    async_packet_fifo #(
        .WIDTH (`PKT_FIFO_WIDTH),
        .DEPTH (`PKT_FIFO_DEPTH),
        .AW    (`PKT_FIFO_AW)
    ) receive_packet_fifo (
        .i_wr_clk   (i_mac_rx_clk),
        .i_wr_rst_n (rx_rst_n_q),
        .i_wr_valid (receive_fifo_write_enable_q),
        .i_wr_data  (receive_fifo_write_data_q),
        .o_wr_ready (),
        .o_wr_count (receive_fifo_fill_count),
        .i_rd_clk   (i_ref_clk),
        .i_rd_rst_n (eng_rst_n_q),
        .o_rd_valid (rx_rd_valid),
        .i_rd_ready (i_eng_rx_rd_en),
        .o_rd_data  (rx_rd_word)
    );

    assign o_eng_rx_valid  = rx_rd_valid;
    assign o_eng_rx_data   = rx_rd_word[`DATA_W-1:0];
    assign o_eng_rx_last   = rx_rd_word[`WORD_LAST_BIT];
    assign o_eng_rx_be_sel = rx_rd_word[`WORD_BESEL_BIT];

    // ============================================================
    // Receive state machine
    localparam [`ST_W-1:0] RX_IDLE     = `ST_IDLE;
    localparam [`ST_W-1:0] RX_TRANSFER = `ST_TRANSFER;
    localparam [`ST_W-1:0] RX_DROP     = `ST_DROP;

    reg  [`ST_W-1:0] rx_state_q;
    reg  [`ST_W-1:0] rx_state_d;
    reg              rx_write_d;
    wire             rx_admit   = receive_fifo_fill_count
                                  < `RX_ADMIT_LIMIT;
    wire             rx_end     = i_mac_rx_tvalid & i_mac_rx_tlast;

    always @* begin
        rx_state_d = rx_state_q;
        rx_write_d = 1'b0;
        case (rx_state_q)
            RX_IDLE: begin
                if (i_mac_rx_tvalid && rx_admit) begin
                    rx_write_d = 1'b1;
                    if (!i_mac_rx_tlast) begin
                        rx_state_d = RX_TRANSFER;
                    end
                end else if (i_mac_rx_tvalid && !i_mac_rx_tlast) begin
                    rx_state_d = RX_DROP;
                end
            end
            RX_TRANSFER: begin
                rx_write_d = i_mac_rx_tvalid;
                if (rx_end) begin
                    rx_state_d = RX_IDLE;
                end
            end
            RX_DROP: begin
                if (rx_end) begin
                    rx_state_d = RX_IDLE;
                end
            end
            default: begin
                rx_state_d = RX_IDLE;
            end
        endcase
    end

    always @(posedge i_mac_rx_clk or negedge rx_rst_n_q) begin
        if (!rx_rst_n_q) begin
            rx_state_q                  <= RX_IDLE;
            receive_fifo_write_enable_q <= 1'b0;
            receive_fifo_write_data_q   <= {`PKT_FIFO_WIDTH{1'b0}};
        end else begin
            rx_state_q                  <= rx_state_d;
            receive_fifo_write_enable_q <= rx_write_d;
            receive_fifo_write_data_q   <= {i_mac_rx_tkeep[`BE_SEL_BIT],
                                            i_mac_rx_tlast,
                                            i_mac_rx_tdata};
        end
    end

endmodule // engine_mac_adapter

// File: tb/engine_mac_adapter_asserts.sv
`timescale 1ns/100ps
`include "engine_mac_adapter_defines.vh"

module engine_mac_adapter_asserts (
    input wire               i_ref_clk,
    input wire               i_arst_n,
    input wire               i_mac_tx_clk,
    input wire [`DATA_W-1:0] o_mac_tx_tdata,
    input wire               o_mac_tx_tvalid,
    input wire               o_mac_tx_tlast,
    input wire [`BE_W-1:0]   o_mac_tx_tkeep,
    input wire               i_mac_tx_tready,
    input wire               i_eng_rx_rd_en,
    input wire               o_eng_rx_valid,
    input wire [`DATA_W-1:0] o_eng_rx_data,
    input wire               o_eng_rx_last
);
default clocking @(posedge i_mac_tx_clk);
endclocking
default disable iff (!i_arst_n);
// ============================================================
// Transmit stream
chk_stall_hold: assert property (
    o_mac_tx_tvalid && !i_mac_tx_tready |=> o_mac_tx_tvalid
    && $stable(o_mac_tx_tdata) && $stable(o_mac_tx_tlast)
    && $stable(o_mac_tx_tkeep)) else $error("stream moved while stalled");
chk_valid_to_end: assert property (
    o_mac_tx_tvalid && !o_mac_tx_tlast |=> o_mac_tx_tvalid)
    else $error("valid dropped inside a frame");
chk_idle_after_last: assert property (
    o_mac_tx_tvalid && o_mac_tx_tlast && i_mac_tx_tready
    |=> !o_mac_tx_tvalid) else $error("valid held after last beat");
chk_update_gap: assert property (
    $fell(o_mac_tx_tvalid) |=> !o_mac_tx_tvalid)
    else $error("no update cycle between frames");
chk_first_needs_ready: assert property (
    $rose(o_mac_tx_tvalid) |-> $past(i_mac_tx_tready))
    else $error("beat loaded without ready");
chk_keep_body: assert property (
    o_mac_tx_tvalid && !o_mac_tx_tlast |-> o_mac_tx_tkeep == `KEEP_ALL)
    else $error("partial keep on body beat");
chk_keep_last: assert property (
    o_mac_tx_tvalid && o_mac_tx_tlast |-> o_mac_tx_tkeep == `KEEP_LONG
    || o_mac_tx_tkeep == `KEEP_SHORT) else $error("bad keep on last beat");
// ============================================================
// Engine receive side; transmit and receive covers
chk_rx_word_hold: assert property (
    @(posedge i_ref_clk)
    o_eng_rx_valid && !i_eng_rx_rd_en |=> o_eng_rx_valid
    && $stable(o_eng_rx_data) && $stable(o_eng_rx_last))
    else $error("receive word lost before pop");
cov_stall: cover property (o_mac_tx_tvalid && !i_mac_tx_tready);
cov_last: cover property (
    o_mac_tx_tvalid && o_mac_tx_tlast && i_mac_tx_tready);
cov_rx_pop: cover property (@(posedge i_ref_clk)
    o_eng_rx_valid && o_eng_rx_last && i_eng_rx_rd_en);
endmodule // engine_mac_adapter_asserts

bind engine_mac_adapter engine_mac_adapter_asserts
    engine_mac_adapter_asserts_i (
    .i_ref_clk, .i_arst_n, .i_mac_tx_clk, .o_mac_tx_tdata, .o_mac_tx_tvalid,
    .o_mac_tx_tlast, .o_mac_tx_tkeep, .i_mac_tx_tready, .i_eng_rx_rd_en,
    .o_eng_rx_valid, .o_eng_rx_data, .o_eng_rx_last);

// File: tb/mac_stream_model.sv
`timescale 1ns/100ps
`include "engine_mac_adapter_defines.vh"

module mac_stream_model (
    input  wire               i_tx_clk,
    input  wire               i_rx_clk,
    input  wire [`DATA_W-1:0] i_tdata,
    input  wire               i_tvalid,
    input  wire               i_tlast,
    input  wire [`BE_W-1:0]   i_tkeep,
    input  wire [1:0]         i_ready_mode,
    output reg                o_tready,
    output reg  [`DATA_W-1:0] o_rx_tdata,
    output reg                o_rx_tvalid,
    output reg                o_rx_tlast,
    output reg  [`BE_W-1:0]   o_rx_tkeep
);
    logic [`DATA_W-1:0] tx_data_q[$];
    logic               tx_last_q[$];
    logic [`BE_W-1:0]   tx_keep_q[$];

    initial begin
        o_tready    = 1'b0;
        o_rx_tdata  = {`DATA_W{1'b0}};
        o_rx_tvalid = 1'b0;
        o_rx_tlast  = 1'b0;
        o_rx_tkeep  = `KEEP_ALL;
    end

    // Mode 0 ready, 1 held off, 2 toggles each cycle
    always @(posedge i_tx_clk) begin
        if (i_tvalid && o_tready) begin
            tx_data_q.push_back(i_tdata);
            tx_last_q.push_back(i_tlast);
            tx_keep_q.push_back(i_tkeep);
        end
        #1;
        o_tready = (i_ready_mode == 2'h0)
            || (i_ready_mode == 2'h2 && !o_tready);
    end

    // No backpressure on receive; idle lines show the inverse of the last beat
    task automatic send_rx(input int n, input int base);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge i_rx_clk);
            #1;
            o_rx_tvalid = 1'b1;
            o_rx_tdata  = {8{base + i}};
            o_rx_tlast  = (i == n - 1);
            o_rx_tkeep  = (i == n - 1) ? `KEEP_SHORT : `KEEP_ALL;
        end
        @(posedge i_rx_clk);
        #1;
        o_rx_tvalid = 1'b0;
        o_rx_tdata  = ~o_rx_tdata;
        o_rx_tlast  = 1'b0;
        o_rx_tkeep  = ~o_rx_tkeep;
        repeat (4) @(posedge i_rx_clk);
    endtask
endmodule // mac_stream_model

// File: tb/engine_mac_adapter_bench.sv
`timescale 1ns/100ps
`include "engine_mac_adapter_defines.vh"

module engine_mac_adapter_bench;
    logic               i_ref_clk, i_arst_n;
    logic               i_mac_tx_clk = 0, i_mac_rx_clk = 0;
    logic               i_eng_tx_wr_en, i_eng_tx_last, i_eng_rx_rd_en;
    logic [`DATA_W-1:0] i_eng_tx_data;
    logic [`BE_W-1:0]   i_eng_tx_byte_en;
    logic [1:0]         mode;
    wire                o_eng_tx_ready, o_eng_rx_valid, o_eng_rx_last;
    wire                o_eng_rx_be_sel, o_mac_tx_tvalid, o_mac_tx_tlast;
    wire                i_mac_tx_tready, i_mac_rx_tvalid, i_mac_rx_tlast;
    wire [`DATA_W-1:0]  o_eng_rx_data, o_mac_tx_tdata, i_mac_rx_tdata;
    wire [`BE_W-1:0]    o_mac_tx_tkeep, i_mac_rx_tkeep;
    int                 num_errors = 0;
    int                 compares = 0;

    engine_mac_adapter engine_mac_adapter_i (.i_ref_clk, .i_arst_n,
        .i_mac_tx_clk, .i_mac_rx_clk, .i_eng_tx_wr_en, .i_eng_tx_data,
        .i_eng_tx_last, .i_eng_tx_byte_en, .o_eng_tx_ready, .i_eng_rx_rd_en,
        .o_eng_rx_valid, .o_eng_rx_data, .o_eng_rx_last, .o_eng_rx_be_sel,
        .o_mac_tx_tdata, .o_mac_tx_tvalid, .o_mac_tx_tlast, .o_mac_tx_tkeep,
        .i_mac_tx_tready, .i_mac_rx_tdata, .i_mac_rx_tvalid, .i_mac_rx_tlast,
        .i_mac_rx_tkeep);
    mac_stream_model mac_stream_model_i (.i_tx_clk(i_mac_tx_clk),
        .i_rx_clk(i_mac_rx_clk), .i_tdata(o_mac_tx_tdata),
        .i_tvalid(o_mac_tx_tvalid), .i_tlast(o_mac_tx_tlast),
        .i_tkeep(o_mac_tx_tkeep), .i_ready_mode(mode),
        .o_tready(i_mac_tx_tready), .o_rx_tdata(i_mac_rx_tdata),
        .o_rx_tvalid(i_mac_rx_tvalid), .o_rx_tlast(i_mac_rx_tlast),
        .o_rx_tkeep(i_mac_rx_tkeep));

    // ============================================================
    // Clocks: link clocks offset so no edge meets a reference edge
    initial begin i_ref_clk = 0; forever #2 i_ref_clk = ~i_ref_clk; end
    initial #3.3 forever #16 i_mac_tx_clk = ~i_mac_tx_clk;
    initial #7.7 forever #16 i_mac_rx_clk = ~i_mac_rx_clk;

    // ============================================================
    // Shared tasks
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic timeout();
        check(1'b0, "wait ran out");
        tally_and_finish();
    endtask

    task automatic push(input int w, input bit last, input bit [31:0] be);
        int n;
        #1;
        i_eng_tx_wr_en   = 1'b1;
        i_eng_tx_data    = {8{w}};
        i_eng_tx_last    = last;
        i_eng_tx_byte_en = be;
        for (n = 0; n < 4000; n++) begin
            @(posedge i_ref_clk);
            if (o_eng_tx_ready === 1'b1) break;
        end
        if (n == 4000) timeout();
    endtask

    task automatic wait_tx(input int cnt);
        int n;
        for (n = 0; n < 40000; n++) begin
            @(posedge i_ref_clk);
            if (mac_stream_model_i.tx_data_q.size() >= cnt) break;
        end
        if (n == 40000) timeout();
    endtask

    task automatic check_tx(input int k, input int w, input bit l,
                            input bit [31:0] kp);
        check(mac_stream_model_i.tx_data_q[k] === {8{w}}, "tx data");
        check(mac_stream_model_i.tx_last_q[k] === l, "tx last");
        check(mac_stream_model_i.tx_keep_q[k] === kp, "tx keep");
    endtask

    // ============================================================
    // Scenarios
    task automatic test_tx_pair();
        int k;
        int w [4] = '{32'h10, 32'h11, 32'h12, 32'h20};
        bit l [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        mode = 2'h0;
        for (k = 0; k < 4; k++)
            push(w[k], l[k], k == 3 ? `KEEP_SHORT : `KEEP_LONG);
        #1 i_eng_tx_wr_en = 1'b0;
        wait_tx(4);
        for (k = 0; k < 4; k++) check_tx(k, w[k], l[k], l[k] ? (k == 3 ?
            `KEEP_SHORT : `KEEP_LONG) : `KEEP_ALL);
        mac_stream_model_i.tx_data_q.delete();
        mac_stream_model_i.tx_last_q.delete();
        mac_stream_model_i.tx_keep_q.delete();
        $display("test_tx_pair done");
    endtask

    // MAC held off while the FIFO fills, then stalls every other beat
    task automatic test_tx_full();
        int k;
        mode = 2'h1;
        for (k = 0; k < 512; k++) push(k, k == 511, `KEEP_SHORT);
        #1 i_eng_tx_wr_en = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 check(o_eng_tx_ready === 1'b0, "full fifo still ready");
        mode = 2'h2;
        wait_tx(512);
        for (k = 0; k < 512; k++) check_tx(k, k, k == 511,
            k == 511 ? `KEEP_SHORT : `KEEP_ALL);
        check(o_eng_tx_ready === 1'b1, "fifo not drained");
        $display("test_tx_full done");
    endtask

    // 223 words stored, next packet admitted, the one after dropped
    task automatic test_rx_drop();
        int k, n;
        bit el;
        for (k = 0; k < 6; k++) mac_stream_model_i.send_rx(32, k * 32);
        mac_stream_model_i.send_rx(31, 192);
        mac_stream_model_i.send_rx(2, 223);
        mac_stream_model_i.send_rx(3, 32'h0dea0000);
        repeat (20) @(posedge i_ref_clk);
        #1 i_eng_rx_rd_en = 1'b1;
        for (k = 0; k < 225; k++) begin
            for (n = 0; n < 200; n++) begin
                @(posedge i_ref_clk);
                if (o_eng_rx_valid === 1'b1) break;
            end
            if (n == 200) timeout();
            el = (k < 192) ? (k % 32 == 31) : (k == 222 || k == 224);
            check(o_eng_rx_data === {8{k}}, "rx data");
            check(o_eng_rx_last === el, "rx last");
            check(o_eng_rx_be_sel === !el, "rx keep bit");
        end
        #1 i_eng_rx_rd_en = 1'b0;
        repeat (40) @(posedge i_ref_clk);
        #1 check(o_eng_rx_valid === 1'b0, "dropped packet stored");
        $display("test_rx_drop done");
    endtask

    initial begin
        i_arst_n = 1'b0;
        i_eng_tx_wr_en = 1'b0;
        i_eng_tx_data = {`DATA_W{1'b0}};
        i_eng_tx_last = 1'b0;
        i_eng_tx_byte_en = `KEEP_ALL;
        i_eng_rx_rd_en = 1'b0;
        mode = 2'h0;
        repeat (16) @(posedge i_ref_clk);
        #1 i_arst_n = 1'b1;
        repeat (40) @(posedge i_ref_clk);
        test_tx_pair();
        test_tx_full();
        test_rx_drop();
        tally_and_finish();
    end
endmodule // engine_mac_adapter_bench
